// *** hdl/ttc_top.sv ***
`include "ttc_regs.svh"

// Behaviour
// - Timer function counts once per machine cycle
// - Option bit zero six periods, one twelve
// - Counter samples pin, counts high-then-low
// - Gating needs interrupt pin high plus run
// - Source select: cycles zero, pin edges one
// - Modes 13-bit, 16-bit, 8-bit auto-reload
// - Mode three: timer 1 holds, timer 0 splits
// - Overflow flags set, cleared by vector/software
// - Run bits 0/1 software only
// - Edge flags set on edge, cleared when served
// - Type bits pick falling edge or low level
// - Clock-out enable toggles pin on overflow
// - Down enable lets trigger pin set direction
// - Flag 2 on overflow, not in serial clocking
// - External flag 2 on enabled trigger edge
// - External flag 2 interrupts except up/down
// - Serial clock picks timer 2 or timer 1
// - Trigger ignored unless enabled, and in up/down
// - Run bit 2 and source select for timer 2
// - Capture or reload on trigger, reload overflow
// - Serial clocking forces auto-reload on overflow
// - 8-bit mode reloads low from high byte
// - Split high byte uses run 1, flag 1
// - Up/down reloads, toggles external flag 2
// - Clock-out gives half duty, no interrupt
module ttc_top (
  // System
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  // Pins: event pins, external interrupt pins, trigger input
  input  wire logic [2:0]  event_pins,
  input  wire logic [1:0]  ext_int_pin_x,
  input  wire logic        trigger_input_pin,
  // Interrupt vector acknowledges from the processor
  input  wire logic [1:0]  vec_ack_timer,
  input  wire logic [1:0]  vec_ack_ext,
  // Requests and derived clocks
  output logic      [1:0]  timer_irq_ff,
  output logic      [1:0]  ext_irq_ff,
  output logic             timer2_irq_ff,
  output logic             ser_rx_clk_ff,
  output logic             ser_tx_clk_ff,
  output logic             clock_out_pin_ff
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Decode one timer nibble
  function automatic ttc_pkg::ttc_cfg_t t01_cfg(input logic [3:0] nib);
    t01_cfg = ttc_pkg::ttc_cfg_t'(nib);
  endfunction

  // One counting step of timer 0 or 1
  function automatic ttc_pkg::ttc_res_t t01_step(input ttc_pkg::ttc_mode_t md,
                                                 input logic [7:0] tl, input logic [7:0] th);
    ttc_pkg::ttc_res_t r;
    r = '{ovf: 1'b0, tl: tl, th: th};
    unique case (md)
      ttc_pkg::MODE13: begin
        {r.ovf, r.th, r.tl[4:0]} = {1'b0, th, tl[4:0]} + 14'h0001;
      end
      ttc_pkg::MODE16: begin
        {r.ovf, r.th, r.tl} = {1'b0, th, tl} + 17'h0_0001;
      end
      ttc_pkg::MODE8R: begin
        if (tl == 8'hFF) begin
          r.ovf = 1'b1;
          r.tl  = th;
        end else begin
          r.tl = tl + 8'h01;
        end
      end
      ttc_pkg::MODESPLIT: begin
        {r.ovf, r.tl} = {1'b0, tl} + 9'h001;
      end
    endcase
    t01_step = r;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [5:0]  s1_ff, s2_ff, s3_ff, pin_ff, pin_prev_ff;
  logic [3:0]  mc_cnt_ff;
  logic        mc_tick_ff;
  logic [2:0]  ev_smp_ff;
  logic [7:0]  mode_ff, tl0_ff, th0_ff, tl1_ff, th1_ff, tl2_ff, th2_ff, rcl_ff, rch_ff;
  logic [1:0]  tf_ff, tr_ff, ie_ff, it_ff, aux_ff;
  logic [5:0]  t2cfg_ff;
  logic        tf2_ff, external_flag_2_ff, opt_ff;
  logic [31:0] rd_data;
  logic        map_ok;
  logic        acc, wr;
  logic [7:0]  wd;
  logic [2:0]  ev_fall;
  logic [1:0]  int_fall;
  logic        trig_fall;
  logic [3:0]  mc_last;
  ttc_pkg::ttc_cfg_t cfg0, cfg1;
  ttc_pkg::ttc_res_t r0, r1;
  logic        split, inc0, inc0h, inc1, ovf0, ovf0h, ovf1;
  logic        brg, arud, up, inc2, ovf2_up, ovf2_dn, ovf2, trig_ev, cap, rld_trig, clkout;
  logic [15:0] t2cnt, rcap, nxt_t2;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages; a level is accepted once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_ff       <= `TTC_PIN_IDLE;
      s2_ff       <= `TTC_PIN_IDLE;
      s3_ff       <= `TTC_PIN_IDLE;
      pin_ff      <= `TTC_PIN_IDLE;
      pin_prev_ff <= `TTC_PIN_IDLE;
    end else begin
      s1_ff       <= {trigger_input_pin, event_pins, ext_int_pin_x};
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      pin_ff      <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
      pin_prev_ff <= pin_ff;
    end
  end

  assign int_fall  = pin_prev_ff[1:0] & ~pin_ff[1:0];
  assign trig_fall = pin_prev_ff[5] & ~pin_ff[5];

  // ----------------------------------------
  // Machine cycle
  // ----------------------------------------
  assign mc_last = (opt_ff ? `TTC_MC_LONG : `TTC_MC_SHORT) - 4'h1;

  // Prescaler; a cycle-mode change takes effect at once, on the count in progress
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mc_cnt_ff  <= 4'h0;
      mc_tick_ff <= 1'b0;
    end else begin
      mc_cnt_ff  <= (mc_cnt_ff >= mc_last) ? 4'h0 : mc_cnt_ff + 4'h1;
      mc_tick_ff <= (mc_cnt_ff >= mc_last);
    end
  end

  // Event pins sampled once per machine cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ev_smp_ff <= 3'h7;
    end else if (mc_tick_ff) begin
      ev_smp_ff <= pin_ff[4:2];
    end
  end

  // Pin phases shorter than a machine cycle may be missed
  assign ev_fall = {3{mc_tick_ff}} & ev_smp_ff & ~pin_ff[4:2];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign acc = psel & penable & pready_ff;
  assign wr  = acc & pwrite & map_ok;
  assign wd  = pwdata[7:0];

  // Read mux and address decode
  always_comb begin
    rd_data = 32'h0000_0000;
    map_ok  = (paddr[1:0] == 2'b00);
    unique case ({paddr[7:2], 2'b00})
      `TTC_A_MODE:  rd_data[7:0] = mode_ff;
      `TTC_A_FLAGS: rd_data[7:0] = {tf_ff[1], tr_ff[1], tf_ff[0], tr_ff[0],
                                    ie_ff[1], it_ff[1], ie_ff[0], it_ff[0]};
      `TTC_A_T2AUX: rd_data[1:0] = aux_ff;
      `TTC_A_T2CTL: rd_data[7:0] = {tf2_ff, external_flag_2_ff, t2cfg_ff};
      `TTC_A_TL0:   rd_data[7:0] = tl0_ff;
      `TTC_A_TH0:   rd_data[7:0] = th0_ff;
      `TTC_A_TL1:   rd_data[7:0] = tl1_ff;
      `TTC_A_TH1:   rd_data[7:0] = th1_ff;
      `TTC_A_TL2:   rd_data[7:0] = tl2_ff;
      `TTC_A_TH2:   rd_data[7:0] = th2_ff;
      `TTC_A_RCL:   rd_data[7:0] = rcl_ff;
      `TTC_A_RCH:   rd_data[7:0] = rch_ff;
      `TTC_A_OPT:   rd_data[0]   = opt_ff;
      default:      map_ok       = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      prdata_ff  <= (map_ok & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr_ff <= psel & penable & ~pready_ff & ~map_ok;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Run and type bits change only by software
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_ff  <= `TTC_RST_BYTE;
      tr_ff    <= 2'b00;
      it_ff    <= 2'b00;
      aux_ff   <= 2'b00;
      t2cfg_ff <= 6'h00;
      opt_ff   <= `TTC_RST_OPT;
    end else if (wr) begin
      if (paddr == `TTC_A_MODE)  mode_ff  <= wd;
      if (paddr == `TTC_A_FLAGS) tr_ff    <= {wd[`TTC_B_TR1], wd[`TTC_B_TR0]};
      if (paddr == `TTC_A_FLAGS) it_ff    <= {wd[`TTC_B_IT1], wd[`TTC_B_IT0]};
      if (paddr == `TTC_A_T2AUX) aux_ff   <= {wd[`TTC_B_OE], wd[`TTC_B_DOWN_COUNT_ENABLE]};
      if (paddr == `TTC_A_T2CTL) t2cfg_ff <= wd[`TTC_B_RCLK:`TTC_B_CPRL];
      if (paddr == `TTC_A_OPT)   opt_ff   <= wd[`TTC_B_CYC];
    end
  end

  // ----------------------------------------
  // Timers 0 and 1
  // ----------------------------------------
  assign cfg0  = t01_cfg(mode_ff[3:0]);
  assign cfg1  = t01_cfg(mode_ff[7:4]);
  assign split = (cfg0.mode == ttc_pkg::MODESPLIT);
  assign r0    = t01_step(cfg0.mode, tl0_ff, th0_ff);
  assign r1    = t01_step(cfg1.mode, tl1_ff, th1_ff);

  // Enables: run bit, optional pin gate, then cycle or pin edge
  assign inc0  = tr_ff[0] & (~cfg0.gate | pin_ff[0])
               & (cfg0.count_ev ? ev_fall[0] : mc_tick_ff);
  assign inc1  = tr_ff[1] & (~cfg1.gate | pin_ff[1]) & (cfg1.mode != ttc_pkg::MODESPLIT)
               & (cfg1.count_ev ? ev_fall[1] : mc_tick_ff);
  assign inc0h = split & tr_ff[1] & mc_tick_ff;
  assign ovf0  = inc0 & r0.ovf;
  assign ovf0h = inc0h & (th0_ff == 8'hFF);
  assign ovf1  = inc1 & r1.ovf;

  // Software writes take precedence over counting
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tl0_ff <= `TTC_RST_BYTE;
      th0_ff <= `TTC_RST_BYTE;
    end else begin
      if (wr && paddr == `TTC_A_TL0) tl0_ff <= wd;
      else if (inc0)                 tl0_ff <= r0.tl;
      if (wr && paddr == `TTC_A_TH0) th0_ff <= wd;
      else if (inc0h)                th0_ff <= th0_ff + 8'h01;
      else if (inc0 && !split)       th0_ff <= r0.th;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tl1_ff <= `TTC_RST_BYTE;
      th1_ff <= `TTC_RST_BYTE;
    end else begin
      if (wr && paddr == `TTC_A_TL1) tl1_ff <= wd;
      else if (inc1)                 tl1_ff <= r1.tl;
      if (wr && paddr == `TTC_A_TH1) th1_ff <= wd;
      else if (inc1)                 th1_ff <= r1.th;
    end
  end

  // Overflow flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tf_ff <= 2'b00;
    end else begin
      tf_ff[0] <= ovf0 | ((wr && paddr == `TTC_A_FLAGS) ? wd[`TTC_B_TF0]
                                                       : tf_ff[0] & ~vec_ack_timer[0]);
      tf_ff[1] <= (split ? ovf0h : ovf1)
                | ((wr && paddr == `TTC_A_FLAGS) ? wd[`TTC_B_TF1]
                                                 : tf_ff[1] & ~vec_ack_timer[1]);
    end
  end

  // ----------------------------------------
  // External interrupt flags
  // ----------------------------------------
  // Edge type latches; level type follows the pin so the source owns it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ie_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (it_ff[i]) begin
          ie_ff[i] <= int_fall[i]
                    | ((wr && paddr == `TTC_A_FLAGS) ? wd[`TTC_B_IE0 + 2 * i]
                                                     : ie_ff[i] & ~vec_ack_ext[i]);
        end else begin
          ie_ff[i] <= ~pin_ff[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Timer 2
  // ----------------------------------------
  assign brg      = t2cfg_ff[`TTC_B_RCLK] | t2cfg_ff[`TTC_B_SERIAL_TX_CLOCK_SELECT];
  assign arud     = aux_ff[`TTC_B_DOWN_COUNT_ENABLE] & ~t2cfg_ff[`TTC_B_CPRL] & ~brg;
  assign up       = ~arud | pin_ff[5];
  assign clkout   = aux_ff[`TTC_B_OE] & ~t2cfg_ff[`TTC_B_CT2];
  assign t2cnt    = {th2_ff, tl2_ff};
  assign rcap     = {rch_ff, rcl_ff};
  assign inc2     = t2cfg_ff[`TTC_B_TR2]
                  & (t2cfg_ff[`TTC_B_CT2] ? ev_fall[2] : mc_tick_ff);
  assign ovf2_up  = inc2 & up & (t2cnt == 16'hFFFF);
  assign ovf2_dn  = inc2 & ~up & (t2cnt == rcap);
  assign ovf2     = ovf2_up | ovf2_dn;
  // Trigger edges only count when enabled; in up/down they steer direction
  assign trig_ev  = t2cfg_ff[`TTC_B_EXTERNAL_TRIGGER_ENABLE] & trig_fall & ~arud;
  assign cap      = trig_ev & t2cfg_ff[`TTC_B_CPRL] & ~brg;
  assign rld_trig = trig_ev & ~t2cfg_ff[`TTC_B_CPRL] & ~brg;

  // Next count: trigger reload, then overflow loads, then step
  always_comb begin
    nxt_t2 = t2cnt;
    if (rld_trig) begin
      nxt_t2 = rcap;
    end else if (ovf2_dn) begin
      nxt_t2 = 16'hFFFF;
    end else if (ovf2_up && (brg || !t2cfg_ff[`TTC_B_CPRL])) begin
      nxt_t2 = rcap;
    end else if (inc2) begin
      nxt_t2 = up ? t2cnt + 16'h0001 : t2cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tl2_ff <= `TTC_RST_BYTE;
      th2_ff <= `TTC_RST_BYTE;
    end else begin
      tl2_ff <= (wr && paddr == `TTC_A_TL2) ? wd : nxt_t2[7:0];
      th2_ff <= (wr && paddr == `TTC_A_TH2) ? wd : nxt_t2[15:8];
    end
  end

  // Capture has priority over a software write to the pair
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rcl_ff <= `TTC_RST_BYTE;
      rch_ff <= `TTC_RST_BYTE;
    end else if (cap) begin
      rcl_ff <= tl2_ff;
      rch_ff <= th2_ff;
    end else begin
      if (wr && paddr == `TTC_A_RCL) rcl_ff <= wd;
      if (wr && paddr == `TTC_A_RCH) rch_ff <= wd;
    end
  end

  // Timer 2 flags; software clears them, an up/down overflow toggles the external flag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tf2_ff  <= 1'b0;
      external_flag_2_ff <= 1'b0;
    end else begin
      tf2_ff  <= (ovf2 & ~brg & ~clkout)
               | ((wr && paddr == `TTC_A_T2CTL) ? wd[`TTC_B_TF2] : tf2_ff);
      if (arud && ovf2) begin
        external_flag_2_ff <= ~external_flag_2_ff;
      end else begin
        external_flag_2_ff <= trig_ev
                 | ((wr && paddr == `TTC_A_T2CTL) ? wd[`TTC_B_EXTERNAL_FLAG_2] : external_flag_2_ff);
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Registered requests, serial clock pulses and clock-out toggle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      timer_irq_ff     <= 2'b00;
      ext_irq_ff       <= 2'b00;
      timer2_irq_ff    <= 1'b0;
      ser_rx_clk_ff    <= 1'b0;
      ser_tx_clk_ff    <= 1'b0;
      clock_out_pin_ff <= 1'b0;
    end else begin
      timer_irq_ff     <= tf_ff;
      ext_irq_ff       <= ie_ff;
      timer2_irq_ff    <= tf2_ff | (external_flag_2_ff & ~arud);
      ser_rx_clk_ff    <= t2cfg_ff[`TTC_B_RCLK] ? ovf2 : ovf1;
      ser_tx_clk_ff    <= t2cfg_ff[`TTC_B_SERIAL_TX_CLOCK_SELECT] ? ovf2 : ovf1;
      if (aux_ff[`TTC_B_OE] && ovf2) begin
        clock_out_pin_ff <= ~clock_out_pin_ff;
      end
    end
  end

endmodule

// *** inc/ttc_pkg.sv ***
package ttc_pkg;
  // Operating modes of timers 0 and 1
  typedef enum logic [1:0] {MODE13, MODE16, MODE8R, MODESPLIT} ttc_mode_t;
  // One timer nibble of the mode register
  typedef struct packed {
    logic      gate;
    logic      count_ev;
    ttc_mode_t mode;
  } ttc_cfg_t;
  // Result of one counting step
  typedef struct packed {
    logic       ovf;
    logic [7:0] tl;
    logic [7:0] th;
  } ttc_res_t;
endpackage

// *** inc/ttc_regs.svh ***
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TTC_A_MODE   8'h00
`define TTC_A_FLAGS  8'h04
`define TTC_A_T2AUX  8'h08
`define TTC_A_T2CTL  8'h0C
`define TTC_A_TL0    8'h10
`define TTC_A_TH0    8'h14
`define TTC_A_TL1    8'h18
`define TTC_A_TH1    8'h1C
`define TTC_A_TL2    8'h20
`define TTC_A_TH2    8'h24
`define TTC_A_RCL    8'h28
`define TTC_A_RCH    8'h2C
`define TTC_A_OPT    8'h30
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TTC_B_TF1    7
`define TTC_B_TR1    6
`define TTC_B_TF0    5
`define TTC_B_TR0    4
`define TTC_B_IE1    3
`define TTC_B_IT1    2
`define TTC_B_IE0    1
`define TTC_B_IT0    0
`define TTC_B_TF2    7
`define TTC_B_EXTERNAL_FLAG_2   6
`define TTC_B_RCLK   5
`define TTC_B_SERIAL_TX_CLOCK_SELECT   4
`define TTC_B_EXTERNAL_TRIGGER_ENABLE  3
`define TTC_B_TR2    2
`define TTC_B_CT2    1
`define TTC_B_CPRL   0
`define TTC_B_OE     1
`define TTC_B_DOWN_COUNT_ENABLE   0
`define TTC_B_CYC    0
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define TTC_RST_BYTE 8'h00
`define TTC_RST_OPT  1'b1
`define TTC_PIN_IDLE 6'h3F
`define TTC_MC_LONG  4'hC
`define TTC_MC_SHORT 4'h6
`endif

// *** tb/three_timer_counter_unit_tb.sv ***
`include "ttc_regs.svh"

module three_timer_counter_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [2:0]  event_pins;
  logic [1:0]  ext_int_pin_x;
  logic        trigger_input_pin;
  logic [1:0]  vec_ack_timer = 2'h0;
  logic [1:0]  vec_ack_ext = 2'h0;
  logic [1:0]  timer_irq_ff;
  logic [1:0]  ext_irq_ff;
  logic        timer2_irq_ff;
  logic        ser_rx_clk_ff;
  logic        ser_tx_clk_ff;
  logic        clock_out_pin_ff;
  logic [7:0]  q;
  logic        err;
  int          n;
  int          mismatches = 0;
  int          num_checks = 0;

  ttc_top        i_ttc_top (.*);
  ttc_pins_model i_ttc_pins_model (.*);

  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Cycle count checks, exact and bounded
  task automatic cnt(input string nm, input int e);
    cmp(nm, 16'(e), 16'(n));
  endtask
  task automatic le(input string nm, input int b);
    cmp(nm, 16'h0001, {15'h0000, n <= b});
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready_ff !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      end_sim();
    end
    q   = prdata_ff[7:0];
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  // Wait for an output level, counting cycles; a hang ends the run
  task automatic wait_lvl(input int s, input logic v);
    logic x;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      case (s)
        0: x = ser_tx_clk_ff;
        1: x = clock_out_pin_ff;
        2: x = timer_irq_ff[0];
        3: x = timer_irq_ff[1];
        4: x = ext_irq_ff[0];
        6: x = ser_rx_clk_ff;
        default: x = timer2_irq_ff;
      endcase
    end while (x !== v && n < 3000);
    if (n >= 3000) begin
      mismatches++;
      end_sim();
    end
  endtask
  // Vector acknowledge pulse, timer or external 0
  task automatic pulse(input logic ext);
    vec_ack_timer <= {1'b0, ~ext};
    vec_ack_ext   <= {1'b0, ext};
    @(posedge clk_sys);
    vec_ack_timer <= 2'h0;
    vec_ack_ext   <= 2'h0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // Reset values, then an unmapped word is refused
    for (int a = 0; a <= 48; a += 4) rd(8'(a), (a == 48) ? {7'h00, `TTC_RST_OPT} : `TTC_RST_BYTE);
    apb(1'b0, 8'h34, 8'h00);
    cmp("slverr", 16'h0001, {15'h0000, err});
    // Timer 1 reload period seen on the transmit clock, long then short cycles
    wr(`TTC_A_MODE, 8'h20);
    wr(`TTC_A_TH1, 8'hF0);
    // Start near the top so the first overflow falls well inside the wait limit
    wr(`TTC_A_TL1, 8'hF0);
    wr(`TTC_A_FLAGS, 8'h40);
    for (int m = 1; m >= 0; m--) begin
      wr(`TTC_A_OPT, 8'(m));
      repeat (3) wait_lvl(0, 1'b1);
      cnt("tx period", 16 * (m ? `TTC_MC_LONG : `TTC_MC_SHORT));
    end
    wr(`TTC_A_OPT, 8'h01);
    // Receive clock also follows timer 1 while its select bit is clear
    repeat (2) wait_lvl(6, 1'b1);
    cnt("rx period", 16 * `TTC_MC_LONG);
    rd(`TTC_A_TH1, 8'hF0);
    // Split timer 0: high byte runs on run bit 1; timer 1 holds
    wr(`TTC_A_MODE, 8'h33);
    wr(`TTC_A_TH0, 8'hFE);
    wr(`TTC_A_TL1, 8'h5A);
    wr(`TTC_A_FLAGS, 8'h40);
    wait_lvl(3, 1'b1);
    le("split flag 1", 40);
    cmp("split flag 0", 16'h0000, {15'h0000, timer_irq_ff[0]});
    rd(`TTC_A_TL1, 8'h5A);
    wr(`TTC_A_FLAGS, 8'h00);
    rd(`TTC_A_FLAGS, 8'h00);
    // Timer 0 overflow flag, cleared by the vector acknowledge
    wr(`TTC_A_MODE, 8'h01);
    wr(`TTC_A_TL0, 8'hFE);
    wr(`TTC_A_TH0, 8'hFF);
    wr(`TTC_A_FLAGS, 8'h10);
    wait_lvl(2, 1'b1);
    rd(`TTC_A_FLAGS, 8'h30);
    pulse(1'b0);
    wait_lvl(2, 1'b0);
    le("ack clear", 3);
    rd(`TTC_A_FLAGS, 8'h10);
    // Gated event counting: edges count only while interrupt pin 0 is high
    wr(`TTC_A_FLAGS, 8'h00);
    wr(`TTC_A_MODE, 8'h0D);
    wr(`TTC_A_TL0, 8'h00);
    wr(`TTC_A_TH0, 8'h00);
    wr(`TTC_A_FLAGS, 8'h10);
    i_ttc_pins_model.set_pin(3, 1'b0);
    i_ttc_pins_model.falls(0, 3);
    i_ttc_pins_model.set_pin(3, 1'b1);
    i_ttc_pins_model.falls(0, 2);
    wr(`TTC_A_FLAGS, 8'h00);
    rd(`TTC_A_TL0, 8'h02);
    // External interrupt 0: edge flag with acknowledge, then level mode
    wr(`TTC_A_FLAGS, 8'h01);
    i_ttc_pins_model.set_pin(3, 1'b0);
    wait_lvl(4, 1'b1);
    le("edge flag", 10);
    rd(`TTC_A_FLAGS, 8'h03);
    pulse(1'b1);
    wait_lvl(4, 1'b0);
    le("edge ack", 3);
    wr(`TTC_A_FLAGS, 8'h00);
    wait_lvl(4, 1'b1);
    le("level low", 4);
    i_ttc_pins_model.set_pin(3, 1'b1);
    wait_lvl(4, 1'b0);
    le("level high", 10);
    // Timer 2 as transmit clock with clock-out: no overflow flag
    wr(`TTC_A_RCL, 8'hF0);
    wr(`TTC_A_RCH, 8'hFF);
    wr(`TTC_A_TH2, 8'hFF);
    wr(`TTC_A_TL2, 8'hF0);
    wr(`TTC_A_T2AUX, 8'h02);
    wr(`TTC_A_T2CTL, 8'h14);
    wait_lvl(1, 1'b1);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    cnt("clock out half", 16 * `TTC_MC_LONG);
    repeat (2) wait_lvl(0, 1'b1);
    cnt("t2 tx period", 16 * `TTC_MC_LONG);
    rd(`TTC_A_T2CTL, 8'h14);
    // Plain auto-reload: flag set, count reloaded from the pair
    wr(`TTC_A_T2AUX, 8'h00);
    wr(`TTC_A_T2CTL, 8'h04);
    wait_lvl(5, 1'b1);
    le("t2 overflow", 250);
    rd(`TTC_A_T2CTL, 8'h84);
    rd(`TTC_A_TH2, 8'hFF);
    // Capture on trigger fall, then trigger ignored when not enabled
    wr(`TTC_A_T2CTL, 8'h00);
    wr(`TTC_A_TL2, 8'h34);
    wr(`TTC_A_TH2, 8'h12);
    wr(`TTC_A_T2CTL, 8'h09);
    i_ttc_pins_model.set_pin(5, 1'b0);
    wait_lvl(5, 1'b1);
    le("capture flag", 10);
    rd(`TTC_A_RCL, 8'h34);
    rd(`TTC_A_RCH, 8'h12);
    i_ttc_pins_model.set_pin(5, 1'b1);
    wr(`TTC_A_T2CTL, 8'h01);
    wr(`TTC_A_TL2, 8'h77);
    i_ttc_pins_model.falls(5, 1);
    rd(`TTC_A_RCL, 8'h34);
    rd(`TTC_A_T2CTL, 8'h01);
    // Down counting: underflow loads all ones and toggles the external flag
    // Direction pin settles low through the filter before the timer starts
    i_ttc_pins_model.set_pin(5, 1'b0);
    wr(`TTC_A_RCL, 8'h00);
    wr(`TTC_A_RCH, 8'h10);
    wr(`TTC_A_TL2, 8'h02);
    wr(`TTC_A_TH2, 8'h10);
    wr(`TTC_A_T2AUX, 8'h01);
    wr(`TTC_A_T2CTL, 8'h04);
    wait_lvl(5, 1'b1);
    le("down overflow", 60);
    rd(`TTC_A_T2CTL, 8'hC4);
    rd(`TTC_A_TH2, 8'hFF);
    wr(`TTC_A_T2CTL, 8'h44);
    wait_lvl(5, 1'b0);
    le("no ext request", 3);
    end_sim();
  end
endmodule

bind ttc_top ttc_top_props i_ttc_top_props (.*);

// *** tb/ttc_pins_model.sv ***
`include "ttc_regs.svh"

module ttc_pins_model (
  // Clock
  input  wire logic       clk_sys,
  // Pins toward the block
  output logic      [2:0] event_pins,
  output logic      [1:0] ext_int_pin_x,
  output logic            trigger_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle high through their pull-ups: {trigger, ext 1:0, event 2:0}
  logic [5:0] pin_ff = `TTC_PIN_IDLE;
  assign {trigger_input_pin, ext_int_pin_x, event_pins} = pin_ff;
  // One pin level, changed just after an edge
  task automatic set_pin(input int k, input logic v);
    @(posedge clk_sys);
    pin_ff[k] <= v;
  endtask
  // Phases outlast a machine cycle plus the input filter, so no edge is lost
  task automatic falls(input int k, input int n);
    repeat (n) begin
      set_pin(k, 1'b0);
      repeat (16) @(posedge clk_sys);
      set_pin(k, 1'b1);
      repeat (16) @(posedge clk_sys);
    end
  endtask
endmodule

// *** tb/ttc_top_props.sv ***
module ttc_top_props (
  // System
  input wire logic        clk_sys,
  input wire logic        nrst,
  // APB slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // Pins and acknowledges
  input wire logic [2:0]  event_pins,
  input wire logic [1:0]  ext_int_pin_x,
  input wire logic        trigger_input_pin,
  input wire logic [1:0]  vec_ack_timer,
  input wire logic [1:0]  vec_ack_ext,
  // Requests and derived clocks
  input wire logic [1:0]  timer_irq_ff,
  input wire logic [1:0]  ext_irq_ff,
  input wire logic        timer2_irq_ff,
  input wire logic        ser_rx_clk_ff,
  input wire logic        ser_tx_clk_ff,
  input wire logic        clock_out_pin_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Completed write; timer requests may only drop two edges after one, timer 0/1 also after an acknowledge
  logic wr_done;
  assign wr_done = psel && penable && pready_ff && pwrite;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_ready_one_wait: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("ready not after one wait state");
  chk_err_reads_zero: assert property (pslverr_ff |-> pready_ff && prdata_ff == 32'h0000_0000)
    else $error("error answer malformed");
  chk_read_upper_zero: assert property (pready_ff |-> prdata_ff[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_tf0_clear_cause: assert property ($fell(timer_irq_ff[0]) && $past(nrst) |->
    $past(vec_ack_timer[0], 2) || $past(wr_done, 2)) else $error("timer 0 request dropped");
  chk_tf1_clear_cause: assert property ($fell(timer_irq_ff[1]) && $past(nrst) |->
    $past(vec_ack_timer[1], 2) || $past(wr_done, 2)) else $error("timer 1 request dropped");
  chk_t2_sw_clear: assert property ($fell(timer2_irq_ff) && $past(nrst) |-> $past(wr_done, 2))
    else $error("timer 2 request dropped");
  chk_tx_pulse_gap: assert property (ser_tx_clk_ff |=> !ser_tx_clk_ff [*5])
    else $error("transmit clock pulses too close");
  chk_rx_pulse_gap: assert property (ser_rx_clk_ff |=> !ser_rx_clk_ff [*5])
    else $error("receive clock pulses too close");
  chk_clkout_half: assert property ($changed(clock_out_pin_ff) |=> $stable(clock_out_pin_ff) [*5])
    else $error("clock out phase too short");
endmodule
